/* design/rtc_irq_regs.svh */
// Offsets, bit positions, masks and reset values of the counter irq block.
// Assumes a 32-bit APB with byte addresses; each register index is word-sized.
`ifndef RTC_IRQ_REGS_SVH
`define RTC_IRQ_REGS_SVH

// Register indices; byte address is four times the index
`define ENABLE_CLEAR_IDX 8'h06
`define ENABLE_SET_IDX 8'h07
`define FLAG_IDX 8'h08
`define SYNC_STATUS_IDX 8'h0a
`define MODE_IDX 8'h20
`define FLAG_CLEAR_IDX 8'h21
`define PENDING_IDX 8'h22

// Bit positions
`define OVERFLOW_BIT 7
`define SYNC_DONE_BIT 6
`define COMPARE_ZERO_BIT 0
`define COMPARE_ONE_BIT 1
`define SYNC_BUSY_BIT 7

// Implemented bits per counter mode
`define MASK_COUNT32 8'hc1
`define MASK_COUNT16 8'hc3
`define MASK_CALENDAR 8'hc1

// Reset values
`define IRQ_RESET 8'h00
`define MODE_RESET 2'h0

`endif

/* design/rtc_irq_pkg.sv */
// Types shared by the counter irq block.
// Assumes rtc_irq_regs.svh supplies the numeric constants.
package rtc_irq_pkg;

    // Counter mode field codes
    typedef enum logic [1:0] {
        COUNT32_MODE = 2'h0,
        COUNT16_MODE = 2'h1,
        CALENDAR_MODE = 2'h2
    } counter_mode_t;

    // Synchronisation tracker states, one-hot
    typedef enum logic [1:0] {
        SYNC_IDLE = 2'h1,
        SYNC_BUSY = 2'h2
    } sync_state_t;

endpackage

/* design/irq_bit_if.sv */
// Carrier between the top and a sticky bit bank.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface irq_bit_if;
    logic [7:0] set_bits; // Per-bit set request
    logic [7:0] clr_bits; // Per-bit clear request
    logic [7:0] valid_bits; // Bits present in current mode
    logic [7:0] state_bits; // Stored bits

    modport ctrl (output set_bits, output clr_bits, output valid_bits, input state_bits);
    modport bank (input set_bits, input clr_bits, input valid_bits, output state_bits);
endinterface
`default_nettype wire

/* design/irq_bit_bank.sv */
// Eight sticky bits with set and clear requests, used for enables and flags.
// Assumes requests are synchronous one-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_regs.svh"
module irq_bit_bank (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    irq_bit_if.bank bits // Set, clear and state
);

    // --------------------------------------------------
    // Per-bit storage
    // --------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
            logic bit_r; // Stored bit
            logic bit_nxt; // Next value
            // Set wins so an event in the clearing cycle survives
            assign bit_nxt = bits.valid_bits[gi] &
                (bits.set_bits[gi] | (bit_r & ~bits.clr_bits[gi]));
            // Zero after reset, nothing pending
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bit_r <= 1'b0;
                end else begin
                    bit_r <= bit_nxt;
                end
            end
            assign bits.state_bits[gi] = bit_r;
        end
    endgenerate

endmodule
`default_nettype wire

/* design/rtc_irq_top.sv */
// Interrupt enable and flag logic of the real-time counter, APB slave.
// Assumes event inputs are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_regs.svh"
module rtc_irq_top (
    input wire logic pclk, // Bus and counter clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic overflow_evt, // Counter overflow pulse
    input wire logic [1:0] compare_evt, // Compare match pulses
    input wire logic alarm_evt, // Alarm-0 match pulse
    input wire logic sync_start, // Domain transfer begins
    input wire logic sync_finish, // Domain transfer ends
    input wire logic sync_ctrl_op, // Transfer is enable or soft reset
    output logic sync_in_progress, // Transfer busy status
    output logic [1:0] counter_mode, // Selected counter mode
    output logic irq // Level interrupt request
);

    // --------------------------------------------------
    // Bus decode
    // --------------------------------------------------
    logic pready_r; // Ready, high in first access cycle
    logic pslverr_r; // Error answer
    logic [31:0] prdata_r; // Read data register
    logic irq_r; // Registered request
    wire [7:0] reg_idx; // Word index
    wire aligned; // Address in mapped window
    wire setup; // Setup phase
    wire access; // Completing access
    wire wr_en; // Write takes effect
    wire hit_enclr; // Enable clear view
    wire hit_enset; // Enable set view
    wire hit_flag; // Flag register
    wire hit_status; // Sync status
    wire hit_mode; // Mode register
    wire hit_flagclr; // Flag clear alias
    wire hit_pend; // Pending status
    wire mapped; // Any register hit

    assign reg_idx = paddr[9:2];
    assign aligned = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign wr_en = access && pwrite;
    assign hit_enclr = aligned && (reg_idx == `ENABLE_CLEAR_IDX);
    assign hit_enset = aligned && (reg_idx == `ENABLE_SET_IDX);
    assign hit_flag = aligned && (reg_idx == `FLAG_IDX);
    assign hit_status = aligned && (reg_idx == `SYNC_STATUS_IDX);
    assign hit_mode = aligned && (reg_idx == `MODE_IDX);
    assign hit_flagclr = aligned && (reg_idx == `FLAG_CLEAR_IDX);
    assign hit_pend = aligned && (reg_idx == `PENDING_IDX);
    assign mapped = hit_enclr | hit_enset | hit_flag | hit_status |
        hit_mode | hit_flagclr | hit_pend;

    // --------------------------------------------------
    // Counter mode
    // --------------------------------------------------
    rtc_irq_pkg::counter_mode_t mode_r; // Current mode
    wire [1:0] mode_wr; // Written mode code
    wire mode_legal; // Written code is a known mode
    wire [7:0] valid_mask; // Implemented bits in this mode

    assign mode_wr = pwdata[1:0];
    assign mode_legal = (mode_wr == rtc_irq_pkg::COUNT32_MODE) ||
        (mode_wr == rtc_irq_pkg::COUNT16_MODE) ||
        (mode_wr == rtc_irq_pkg::CALENDAR_MODE);
    // Layout differs only in bit 1, present in 16-bit mode
    assign valid_mask = (mode_r == rtc_irq_pkg::COUNT16_MODE) ? `MASK_COUNT16 :
        (mode_r == rtc_irq_pkg::CALENDAR_MODE) ? `MASK_CALENDAR :
        `MASK_COUNT32;

    // Unknown codes are dropped so the layout never goes undefined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= rtc_irq_pkg::COUNT32_MODE;
        end else if (wr_en && hit_mode && mode_legal) begin
            mode_r <= rtc_irq_pkg::counter_mode_t'(mode_wr);
        end
    end

    // --------------------------------------------------
    // Synchronisation tracker
    // --------------------------------------------------
    rtc_irq_pkg::sync_state_t sync_state_r; // Tracker state
    rtc_irq_pkg::sync_state_t sync_state_nxt; // Next state
    logic ctrl_op_r; // Transfer was enable or soft reset
    logic ctrl_op_nxt; // Next cause
    logic sync_done_evt; // Busy fell on a plain transfer

    // Busy rises on start and falls on finish
    always_comb begin
        sync_state_nxt = sync_state_r;
        ctrl_op_nxt = ctrl_op_r;
        sync_done_evt = 1'b0;
        case (sync_state_r)
            rtc_irq_pkg::SYNC_IDLE: begin
                if (sync_start) begin
                    sync_state_nxt = rtc_irq_pkg::SYNC_BUSY;
                    ctrl_op_nxt = sync_ctrl_op;
                end
            end
            rtc_irq_pkg::SYNC_BUSY: begin
                if (sync_finish) begin
                    sync_state_nxt = rtc_irq_pkg::SYNC_IDLE;
                    // Control-caused falls raise no flag
                    sync_done_evt = !ctrl_op_r;
                end
            end
            default: begin
                sync_state_nxt = rtc_irq_pkg::SYNC_IDLE;
            end
        endcase
    end

    // Tracker state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_state_r <= rtc_irq_pkg::SYNC_IDLE;
            ctrl_op_r <= 1'b0;
        end else begin
            sync_state_r <= sync_state_nxt;
            ctrl_op_r <= ctrl_op_nxt;
        end
    end

    // --------------------------------------------------
    // Enable bank
    // --------------------------------------------------
    irq_bit_if en_if(); // Enable carrier
    wire [7:0] enables; // Shared enable bits
    wire [7:0] wr_bits; // Write data, implemented bits only

    assign wr_bits = pwdata[7:0] & valid_mask;
    // One bank serves both views, so either write is seen by both
    assign en_if.set_bits = (wr_en && hit_enset) ? wr_bits : 8'h00;
    assign en_if.clr_bits = (wr_en && hit_enclr) ? wr_bits : 8'h00;
    assign en_if.valid_bits = valid_mask;
    assign enables = en_if.state_bits;

    irq_bit_bank u_enable (
        .pclk(pclk),
        .presetn(presetn),
        .bits(en_if.bank)
    );

    // --------------------------------------------------
    // Flag bank
    // --------------------------------------------------
    irq_bit_if fl_if(); // Flag carrier
    logic [7:0] hw_set; // Hardware set requests
    wire [7:0] flags; // Sticky flags
    wire flag_clr_hit; // Either clear view addressed

    // Events are captured at the edge closing their cycle
    always_comb begin
        hw_set = 8'h00;
        hw_set[`OVERFLOW_BIT] = overflow_evt;
        hw_set[`SYNC_DONE_BIT] = sync_done_evt;
        // Bit 0 source follows the mode
        hw_set[`COMPARE_ZERO_BIT] = (mode_r == rtc_irq_pkg::CALENDAR_MODE) ?
            alarm_evt : compare_evt[0];
        hw_set[`COMPARE_ONE_BIT] = compare_evt[1];
    end

    assign flag_clr_hit = hit_flag || hit_flagclr;
    assign fl_if.set_bits = hw_set;
    assign fl_if.clr_bits = (wr_en && flag_clr_hit) ? wr_bits : 8'h00;
    assign fl_if.valid_bits = valid_mask;
    assign flags = fl_if.state_bits;

    irq_bit_bank u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .bits(fl_if.bank)
    );

    // --------------------------------------------------
    // Read data and answer
    // --------------------------------------------------
    wire [7:0] pending; // Enabled and set
    wire [7:0] status_byte; // Busy at bit 7
    wire [7:0] rd_byte; // Selected byte

    assign pending = flags & enables;
    assign status_byte = {(sync_state_r == rtc_irq_pkg::SYNC_BUSY), 7'h00};
    // Write-only clear alias and unmapped space read zero
    assign rd_byte = (hit_enclr || hit_enset) ? enables :
        hit_flag ? flags :
        hit_status ? status_byte :
        hit_mode ? {6'h00, mode_r} :
        hit_pend ? pending :
        8'h00;

    // No wait state: data and ready settle in the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            // Data is a snapshot taken one edge before completion
            prdata_r <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // --------------------------------------------------
    // Interrupt output
    // --------------------------------------------------
    // Registered so the pin is glitch free; lags the flag by one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |pending;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign sync_in_progress = sync_state_r[1];
    assign counter_mode = mode_r;

endmodule
`default_nettype wire

/* testbench/rtc_irq_top_sva.sv */
// Port-level checker for the counter irq block.
// Assumes one clock, pclk, and the async active-low reset presetn.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_top_sva (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic overflow_evt, // Overflow pulse
    input wire logic [1:0] compare_evt, // Compare pulses
    input wire logic alarm_evt, // Alarm pulse
    input wire logic sync_start, // Transfer begins
    input wire logic sync_finish, // Transfer ends
    input wire logic sync_in_progress, // Busy status
    input wire logic [1:0] counter_mode, // Counter mode
    input wire logic irq // Interrupt request
);
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr_done = psel && penable && pwrite && pready; // Write takes effect
    wire logic flag_rd = psel && !penable && !pwrite && paddr == 12'h020; // Flag read setup
    // Only events and writes may change the request, two edges later
    wire logic any_evt = overflow_evt || (|compare_evt) || alarm_evt || sync_finish;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    chk_irq_reset: assert property (!$past(presetn) |-> !irq && !sync_in_progress)
        else $error("request or busy after reset");
    chk_irq_cause: assert property ($rose(irq) |-> $past(any_evt || wr_done, 2))
        else $error("request rose without cause");
    chk_irq_drop: assert property ($fell(irq) |-> $past(wr_done, 2))
        else $error("request fell without a write");
    chk_busy_rise: assert property (sync_start && !sync_in_progress |=> sync_in_progress)
        else $error("busy did not rise");
    chk_busy_fall: assert property (sync_finish && sync_in_progress |=> !sync_in_progress)
        else $error("busy did not fall");
    chk_busy_hold: assert property (sync_in_progress && !sync_finish |=> sync_in_progress)
        else $error("busy fell early");
    // A flag read two cycles after the pulse, with no write in between
    chk_ovf_flag: assert property (overflow_evt ##1 !wr_done ##1 flag_rd |=> prdata[7])
        else $error("overflow flag not seen");
    // Bit 1 exists in the 16-bit mode only
    chk_unused_zero: assert property (pready && paddr[9:2] inside {8'h06, 8'h07, 8'h08} |->
        prdata[31:8] == 24'h0 && prdata[5:2] == 4'h0 && (counter_mode == 2'h1 || !prdata[1]))
        else $error("unused bit read as one");
    cov_irq: cover property ($rose(irq));
    cov_sync: cover property (sync_finish && sync_in_progress);
    cov_err: cover property (pready && pslverr);
endmodule

bind rtc_irq_top rtc_irq_top_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflow_evt(overflow_evt), .compare_evt(compare_evt), .alarm_evt(alarm_evt),
    .sync_start(sync_start), .sync_finish(sync_finish), .sync_in_progress(sync_in_progress),
    .counter_mode(counter_mode), .irq(irq));
`default_nettype wire

/* testbench/rtc_irq_top_tb.sv */
// Self-checking bench for the counter irq block.
// Assumes the APB answer comes with pready; events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module rtc_irq_top_tb;
    logic pclk = 1'b0; // Clock
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [11:0] paddr = 12'h000; // APB address
    logic [31:0] pwdata = 32'h0; // APB write data
    logic overflow_evt = 1'b0, alarm_evt = 1'b0, sync_start = 1'b0, sync_finish = 1'b0; // Events
    logic sync_ctrl_op = 1'b0; // Control transfer marker
    logic [1:0] compare_evt = 2'h0; // Compare pulses
    wire logic [31:0] prdata; // Read data
    wire logic [1:0] counter_mode; // Mode
    wire logic pready, pslverr, sync_in_progress, irq; // Status outputs
    int miscompares = 0, n_tests = 0; // Counters
    logic [9:0] exp_q[$]; // Notes: is_read, error, data
    logic [9:0] e; // Oldest note
    logic [7:0] r; // Random clear pattern
    int m; // Mode index
    logic [7:0] cmp_fl[3] = '{8'h01, 8'h03, 8'h00}; // Flags after compare pulses
    logic [7:0] alm_fl[3] = '{8'h00, 8'h00, 8'h01}; // Flags after alarm pulse
    logic [7:0] mask[3] = '{8'hc1, 8'hc3, 8'hc1}; // Bits present per mode
    logic [11:0] regs[5] = '{12'h018, 12'h01c, 12'h020, 12'h028, 12'h088}; // Readable places

    always #2 pclk = ~pclk;

    rtc_irq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overflow_evt(overflow_evt), .compare_evt(compare_evt), .alarm_evt(alarm_evt),
        .sync_start(sync_start), .sync_finish(sync_finish), .sync_ctrl_op(sync_ctrl_op),
        .sync_in_progress(sync_in_progress), .counter_mode(counter_mode), .irq(irq));

    // ------------------------------------------------
    // Bus and event drivers
    // ------------------------------------------------
    // One transfer; the idle cycle after it keeps drivers from colliding
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [8:0] x,
        input logic ov = 1'b0);
        logic [31:0] rnd;
        rnd = $urandom;
        exp_q.push_back({~w, x});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        // Upper bits stay zero on mapped registers; only refused transfers carry noise there
        pwdata <= {x[8] ? rnd[31:8] : 24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        overflow_evt <= ov;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        overflow_evt <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {1'b0, d});
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 9'h000);
    endtask
    // Pulse: overflow, compare[1:0], alarm, start, finish
    task automatic pulse(input logic [5:0] v);
        {overflow_evt, compare_evt, alarm_evt, sync_start, sync_finish} <= v;
        @(posedge pclk);
        {overflow_evt, compare_evt, alarm_evt, sync_start, sync_finish} <= 6'h00;
        repeat (2) @(posedge pclk);
    endtask
    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------
    // Result watcher
    // ------------------------------------------------
    // Read data is not defined on a write answer, so only the error is compared
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(pslverr, e[8])
            if (e[9]) `CHK(prdata, {24'h0, e[7:0]})
        end
    end

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        finish_test;
    end

    // Main sequence
    initial begin
        void'($urandom(17121));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (regs[i]) rd(regs[i], 8'h00);
        for (m = 0; m < 3; m++) begin
            wr(12'h080, 8'(m));
            `CHK(counter_mode, 2'(m))
            rd(12'h080, 8'(m));
            wr(12'h01c, mask[m]);
            rd(12'h018, mask[m]);
            r = 8'($urandom) & mask[m];
            wr(12'h018, r);
            rd(12'h01c, mask[m] & ~r);
            wr(12'h018, mask[m]);
            pulse(6'b011000);
            `CHK(irq, 1'b0)
            rd(12'h020, cmp_fl[m]);
            wr(12'h020, mask[m]);
            pulse(6'b000100);
            rd(12'h020, alm_fl[m]);
            wr(12'h020, mask[m]);
        end
        wr(12'h080, 8'h00);
        // Code 3 names no mode and must leave the layout alone
        wr(12'h080, 8'h03);
        rd(12'h080, 8'h00);
        `CHK(counter_mode, 2'h0)
        wr(12'h01c, 8'h80);
        pulse(6'b100000);
        `CHK(irq, 1'b1)
        rd(12'h088, 8'h80);
        wr(12'h020, 8'h00);
        rd(12'h020, 8'h80);
        wr(12'h020, 8'h80);
        rd(12'h020, 8'h00);
        `CHK(irq, 1'b0)
        apb(1'b1, 12'h020, 8'h80, 9'h000, 1'b1);
        rd(12'h020, 8'h80);
        // Clear through the write-only alias, which reads zero
        wr(12'h084, 8'h80);
        rd(12'h084, 8'h00);
        wr(12'h01c, 8'h40);
        // Plain transfer first, then one marked as control
        for (m = 0; m < 2; m++) begin
            sync_ctrl_op <= m[0];
            pulse(6'b000010);
            rd(12'h028, 8'h80);
            pulse(6'b000001);
            rd(12'h028, 8'h00);
            rd(12'h020, m ? 8'h00 : 8'h40);
            `CHK(irq, m ? 1'b0 : 1'b1)
            wr(12'h020, 8'hc1);
        end
        apb(1'b0, 12'h040, 8'h00, 9'h100);
        apb(1'b1, 12'h419, 8'hff, 9'h100);
        rd(12'h01c, 8'hc0);
        finish_test;
    end
endmodule
`default_nettype wire
